/* hw/lsfc_host.sv */
// Host controller that services a LIN slave core through its register port.
// Assumes the core holds its interrupt as a level until the clear command is written.
// Notes on behaviour
// RULE1: Load bit timing before any traffic
// RULE2: Core syncs to header from master
// RULE3: Core interrupts on id, wake, error, done
// RULE4: Header flag set; identifier then readable
// RULE5: Direction bit: 1 transmit, 0 receive
// RULE6: Write length and checksum kind; 1111b auto
// RULE7: Transmit setup finished within response space
// RULE8: Receive acknowledge before first data byte
// RULE9: Unknown identifier: write stop, not acknowledge
// RULE10: Wake unanswered 150ms sets timeout and wake
// RULE11: Check wake before completion flag
// RULE12: Completion set; receive bytes then readable
// RULE13: Clear interrupt and errors ending service
// RULE14: Sleep frame decoded: set sleep bit
// RULE15: Idle timeout sets sleep and idle flags
// RULE16: Wake report: clear sleep bit
// RULE17: Sleep bit zero ignores dominant wake
// RULE18: Wake command makes core send wake
// RULE19: Wake repeat timeout flags error, interrupts
// RULE20: Mismatch or timeouts abandon frame, interrupt
// RULE21: No frame or wake while error set
// RULE22: Pass switch joins upstream and downstream
// RULE23: Idle select maps to 4..10 seconds
// RULE24: Wake select maps to 180..240 ms
// RULE25: Auto length from identifier bits 5:4
// RULE26: Interrupt stays high until cleared
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module lsfc_host
  import lsfc_pkg::*;
(
  input  logic          clock,
  input  logic          reset,
  input  logic [3:0]    swAddr,
  input  logic [7:0]    swWdata,
  input  logic          swWr,
  input  logic          swRd,
  output logic [7:0]    swRdata,
  output lsfc_dev_req_t devReq,
  input  logic [7:0]    devRdata,
  input  logic          devIrq
);
  lsfc_state_t stReg;
  logic [2:0]  idxReg;
  logic        dirReg;
  logic        lastRxReg;
  logic        sleepReg;
  logic        devErrReg;
  logic        initPend;
  logic        wakePend;
  logic        sleepPend;
  logic        passPend;
  logic        passReg;
  logic        chkReg;
  logic [5:0]  idReg;
  logic [5:0]  txIdReg;
  logic [5:0]  rxIdReg;
  logic [3:0]  timeReg;
  logic [7:0]  errCodeReg;
  logic [7:0]  statReg;
  logic [2:0]  evReg;
  logic [2:0]  flagsReg;
  logic [7:0]  txBuf [8];
  logic [7:0]  rxBuf [8];
  logic [7:0]  sleepBits;
  logic        ctrlWr;
  logic [4:0]  dataAddr;

  function automatic lsfc_dev_req_t devWrite(logic [4:0] a, logic [7:0] d);
    return '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endfunction

  function automatic lsfc_dev_req_t devRead(logic [4:0] a);
    return '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
  endfunction

  // Every control write repeats the sleep state so no write wakes the node by accident
  assign sleepBits = sleepReg ? CM_SLEEP : 8'h00; // RULE17
  assign ctrlWr    = swWr && (swAddr == H_CTRL);
  assign dataAddr  = D_DATA + {2'h0, idxReg};

  // Service sequencer: one device access per cycle, reads answered in the next
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stReg      <= ST_IDLE;
      devReq     <= '0;
      idxReg     <= '0;
      dirReg     <= 1'b0;
      lastRxReg  <= 1'b0;
      sleepReg   <= 1'b0;
      devErrReg  <= 1'b0;
      initPend   <= 1'b0;
      wakePend   <= 1'b0;
      sleepPend  <= 1'b0;
      passPend   <= 1'b0;
      passReg    <= 1'b0;
      idReg      <= '0;
      errCodeReg <= '0;
      statReg    <= '0;
      evReg      <= '0;
    end else begin
      devReq.wr <= 1'b0;
      devReq.rd <= 1'b0;
      evReg     <= '0;
      case (stReg)
        ST_IDLE: begin
          if (devIrq) begin
            devReq <= devRead(D_STAT); // RULE3
            stReg  <= ST_EVAL;
          end else if (initPend) begin
            initPend <= 1'b0;
            devReq   <= devWrite(D_BTLO, BTLO_VAL); // RULE1
            stReg    <= ST_BT2;
          end else if (passPend) begin
            passPend <= 1'b0;
            devReq   <= devWrite(D_SW, {7'h00, passReg}); // RULE22
          end else if (sleepPend) begin
            sleepPend <= 1'b0;
            sleepReg  <= 1'b1;
            devReq    <= devWrite(D_CTRL, CM_SLEEP); // RULE14
          end else if (wakePend && !devErrReg) begin
            // A wake asked for during an error waits until the flags are cleared
            wakePend <= 1'b0;
            devReq   <= devWrite(D_CTRL, sleepBits | CM_WAKE); // RULE18 RULE21
          end
        end
        ST_BT2: begin
          devReq <= devWrite(D_BTHI, BTHI_VAL); // RULE1
          stReg  <= ST_BT3;
        end
        ST_BT3: begin
          devReq <= devWrite(D_TIME, {4'h0, timeReg}); // RULE23 RULE24
          stReg  <= ST_IDLE;
        end
        ST_EVAL: begin
          statReg <= devRdata;
          if (devRdata[S_HDR]) begin
            devReq <= devRead(D_ID); // RULE4
            stReg  <= ST_GETID;
          end else if (devRdata[S_ERR]) begin
            devReq <= devRead(D_ERR); // RULE20
            stReg  <= ST_GETERR;
          end else if (devRdata[S_IDLE]) begin
            sleepReg <= 1'b1; // RULE15
            stReg    <= ST_CLEAR;
          end else if (devRdata[S_WAKE]) begin
            // Wake is looked at before completion, and the clear after a wake also drops the completion
            sleepReg <= 1'b0; // RULE11 RULE16
            evReg[2] <= 1'b1;
            devReq   <= devWrite(D_CTRL, 8'h00);
            stReg    <= ST_CLEAR;
          end else if (devRdata[S_DONE] && lastRxReg) begin
            idxReg <= '0; // RULE12
            stReg  <= ST_RDDATA;
          end else begin
            stReg <= ST_CLEAR;
          end
        end
        ST_GETID: begin
          idReg  <= devRdata[5:0];
          idxReg <= '0;
          if (devRdata[5:0] == txIdReg) begin
            dirReg <= 1'b1; // RULE5
            stReg  <= ST_LOAD;
          end else if (devRdata[5:0] == rxIdReg) begin
            dirReg <= 1'b0; // RULE5
            stReg  <= ST_DLEN;
          end else begin
            devReq <= devWrite(D_CTRL, sleepBits | CM_STOP); // RULE9
            stReg  <= ST_CLEAR;
          end
        end
        ST_LOAD: begin
          devReq <= devWrite(dataAddr, txBuf[idxReg]);
          idxReg <= idxReg + 3'h1;
          if (idxReg == 3'h7) begin
            stReg <= ST_DLEN;
          end
        end
        ST_DLEN: begin
          devReq <= devWrite(D_DLEN, {chkReg, 3'h0, LEN_AUTO}); // RULE6 RULE25
          stReg  <= ST_ACK;
        end
        ST_ACK: begin
          // Acknowledge comes last, a few cycles after the header, well inside the response space
          devReq    <= devWrite(D_CTRL, sleepBits | CM_ACK | (dirReg ? CM_DIR : 8'h00)); // RULE7 RULE8
          lastRxReg <= !dirReg;
          stReg     <= ST_CLEAR;
        end
        ST_GETERR: begin
          errCodeReg <= devRdata;
          devErrReg  <= 1'b1; // RULE21
          evReg[1]   <= 1'b1;
          evReg[2]   <= statReg[S_WAKE]; // RULE10 RULE19
          stReg      <= ST_CLEAR;
        end
        ST_RDDATA: begin
          devReq <= devRead(dataAddr);
          stReg  <= ST_GETDATA;
        end
        ST_GETDATA: begin
          idxReg <= idxReg + 3'h1;
          if (idxReg == 3'h7) begin
            evReg[0]  <= 1'b1; // RULE12
            lastRxReg <= 1'b0;
            stReg     <= ST_CLEAR;
          end else begin
            stReg <= ST_RDDATA;
          end
        end
        ST_CLEAR: begin
          devReq    <= devWrite(D_CTRL, sleepBits | CM_RSTI | CM_RSTE); // RULE13 RULE26
          devErrReg <= 1'b0;
          stReg     <= ST_WAIT;
        end
        ST_WAIT: begin
          stReg <= ST_IDLE; // Gives the core a cycle to drop its request
        end
        default: begin
          stReg <= ST_IDLE;
        end
      endcase
      // Orders from software come last so a new order beats a same-cycle consume
      if (ctrlWr) begin
        if (swWdata[HC_INIT]) initPend <= 1'b1;
        if (swWdata[HC_WAKE]) wakePend <= 1'b1;
        if (swWdata[HC_SLEEP]) sleepPend <= 1'b1;
        if (swWdata[HC_PASS] != passReg) passPend <= 1'b1;
        passReg <= swWdata[HC_PASS];
      end
    end
  end

  // Received bytes; no reset, contents valid only after a completion
  always_ff @(posedge clock) begin
    if (stReg == ST_GETDATA) begin
      rxBuf[idxReg] <= devRdata;
    end
  end

  // Transmit bytes written by software
  always_ff @(posedge clock) begin
    if (swWr && swAddr[3]) begin
      txBuf[swAddr[2:0]] <= swWdata;
    end
  end

  // Software settings and sticky events; a set beats a clear in the same cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      chkReg   <= 1'b0;
      txIdReg  <= TXID_RST;
      rxIdReg  <= RXID_RST;
      timeReg  <= TIME_RST;
      flagsReg <= '0;
    end else begin
      if (ctrlWr) chkReg <= swWdata[HC_CHK];
      if (swWr && swAddr == H_TXID) txIdReg <= swWdata[5:0];
      if (swWr && swAddr == H_RXID) rxIdReg <= swWdata[5:0];
      if (swWr && swAddr == H_TIME) timeReg <= swWdata[3:0];
      flagsReg <= (flagsReg & ~((swWr && swAddr == H_STAT) ? swWdata[2:0] : 3'h0)) | evReg;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      swRdata <= '0;
    end else if (!swRd) begin
      swRdata <= '0;
    end else if (swAddr[3]) begin
      swRdata <= rxBuf[swAddr[2:0]];
    end else begin
      case (swAddr)
        H_CTRL:  swRdata <= {3'h0, chkReg, passReg, 3'h0};
        H_TXID:  swRdata <= {2'h0, txIdReg};
        H_RXID:  swRdata <= {2'h0, rxIdReg};
        H_TIME:  swRdata <= {4'h0, timeReg};
        H_STAT:  swRdata <= {3'h0, stReg != ST_IDLE, sleepReg, flagsReg};
        H_ERR:   swRdata <= errCodeReg;
        H_ID:    swRdata <= {2'h0, idReg};
        default: swRdata <= '0;
      endcase
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_ctl_wr;
    devReq.wr && devReq.addr == D_CTRL;
  endsequence
  sequence s_dlen_wr;
    devReq.wr && devReq.addr == D_DLEN;
  endsequence

  a_irq_stat_read: assert property (stReg == ST_IDLE && devIrq |=> devReq.rd && devReq.addr == D_STAT) // RULE3
    else $error("status not read on interrupt");
  a_hdr_id_read: assert property (stReg == ST_EVAL && devRdata[S_HDR] |=> devReq.rd && devReq.addr == D_ID) // RULE4
    else $error("identifier not read after header");
  a_dlen_auto: assert property (s_dlen_wr |-> devReq.wdata[3:0] == LEN_AUTO && devReq.wdata[L_CHK] == chkReg) // RULE6
    else $error("length word wrong");
  a_dlen_ack: assert property (s_dlen_wr |=> s_ctl_wr ##0 (devReq.wdata & CM_ACK) != 8'h00) // RULE7
    else $error("acknowledge does not follow length");
  a_ack_clear: assert property ((s_ctl_wr ##0 (devReq.wdata & CM_ACK) != 8'h00)
                                |=> s_ctl_wr ##0 (devReq.wdata & (CM_RSTI | CM_RSTE)) == (CM_RSTI | CM_RSTE)) // RULE13
    else $error("clear does not follow acknowledge");
  a_stop_unknown: assert property (stReg == ST_GETID && devRdata[5:0] != txIdReg && devRdata[5:0] != rxIdReg
                                   |=> s_ctl_wr ##0 devReq.wdata[2:1] == 2'b10) // RULE9
    else $error("unknown identifier not stopped");
  a_wake_no_err: assert property (s_ctl_wr ##0 (devReq.wdata & CM_WAKE) != 8'h00 |-> !$past(devErrReg)) // RULE21
    else $error("wake sent during error");
  a_wake_first: assert property (stReg == ST_EVAL && devRdata[S_WAKE] && !devRdata[S_HDR]
                                 |=> !(devReq.rd && devReq.addr < D_CTRL) [*2]) // RULE11
    else $error("data read on wake");
  a_idle_sleep: assert property (stReg == ST_EVAL && devRdata[S_IDLE] && devRdata[2:1] == 2'b00 |=> sleepReg) // RULE15
    else $error("sleep not tracked on idle");
  a_bt_pair: assert property (devReq.wr && devReq.addr == D_BTLO |=> devReq.wr && devReq.addr == D_BTHI
                              ##1 devReq.wr && devReq.addr == D_TIME) // RULE1
    else $error("bit timing sequence broken");
endmodule // lsfc_host

/* hw/lsfc_pkg.sv */
// Shared constants and types for the LIN slave frame host controller.
// Assumes a LIN slave core with an 8-bit register port answering reads one cycle later.
package lsfc_pkg;
  // Clock and bit timing set-up, rounded down as the core expects
  localparam int CLK_HZ     = 200_000_000;
  localparam int BIT_HZ     = 20_000;
  localparam int PRESCL_VAL = $clog2(CLK_HZ / (BIT_HZ * 200) + 1) - 1;
  localparam int BTDIV_VAL  = CLK_HZ / ((2 ** PRESCL_VAL) * BIT_HZ);
  localparam logic [7:0] BTLO_VAL = 8'(BTDIV_VAL % 256);
  localparam logic [7:0] BTHI_VAL = 8'((PRESCL_VAL % 4) * 2 + (BTDIV_VAL / 256) % 2);

  // Device register offsets
  localparam logic [4:0] D_DATA = 5'h00,
                         D_CTRL = 5'h08,
                         D_STAT = 5'h09,
                         D_ERR  = 5'h0A,
                         D_DLEN = 5'h0B,
                         D_ID   = 5'h0C,
                         D_BTLO = 5'h0D,
                         D_BTHI = 5'h0E,
                         D_TIME = 5'h0F,
                         D_SW   = 5'h10;
  // Device control masks
  localparam logic [7:0] CM_DIR   = 8'h01,
                         CM_ACK   = 8'h02,
                         CM_STOP  = 8'h04,
                         CM_SLEEP = 8'h08,
                         CM_WAKE  = 8'h10,
                         CM_RSTI  = 8'h20,
                         CM_RSTE  = 8'h40;
  // Device status bit positions
  localparam int S_DONE = 0;
  localparam int S_HDR  = 1;
  localparam int S_ERR  = 2;
  localparam int S_WAKE = 3;
  localparam int S_IDLE = 4;
  localparam int L_CHK  = 7;
  localparam logic [3:0] LEN_AUTO = 4'hF;

  // Host register offsets
  localparam logic [3:0] H_CTRL = 4'h0,
                         H_TXID = 4'h1,
                         H_RXID = 4'h2,
                         H_TIME = 4'h3,
                         H_STAT = 4'h4,
                         H_ERR  = 4'h5,
                         H_ID   = 4'h6;
  localparam int HC_INIT  = 0;
  localparam int HC_WAKE  = 1;
  localparam int HC_SLEEP = 2;
  localparam int HC_PASS  = 3;
  localparam int HC_CHK   = 4;
  localparam logic [5:0] TXID_RST = 6'h00;
  localparam logic [5:0] RXID_RST = 6'h01;
  localparam logic [3:0] TIME_RST = 4'h0;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lsfc_dev_req_t;

  typedef enum {ST_IDLE, ST_BT2, ST_BT3, ST_EVAL, ST_GETID, ST_LOAD, ST_DLEN, ST_ACK,
                ST_GETERR, ST_RDDATA, ST_GETDATA, ST_CLEAR, ST_WAIT} lsfc_state_t;
endpackage

/* tb/lsfc_core_model.sv */
// Behavioural model of the LIN slave core register port facing the host controller.
// Assumes one registered request per cycle from the host and event pulses from the bench.
`timescale 1ns/100ps
module lsfc_core_model
  import lsfc_pkg::*;
(
  input  logic          clock,
  input  logic          reset,
  input  lsfc_dev_req_t devReq,
  output logic [7:0]    devRdata,
  output logic          devIrq,
  input  logic          evHdr,
  input  logic [7:0]    evId,
  input  logic          evDone,
  input  logic          evErr,
  input  logic [7:0]    evCode,
  input  logic          evWake,
  input  logic          evIdle,
  input  logic [63:0]   rxBytes,
  input  logic          seenClr
);
  logic [7:0] statReg, errReg, idReg, ctrlSeen, dlenReg, btloReg, bthiReg, swReg;
  logic [7:0] txMem [0:7];
  logic [7:0] rdVal;
  logic [7:0] junkReg;
  logic [7:0] tmReg;
  logic       wakeSent;
  logic       ctrlWr;
  assign ctrlWr = devReq.wr && devReq.addr == D_CTRL;

  // Read mux; places outside the map read zero
  always_comb begin
    case (devReq.addr)
      D_STAT:  rdVal = statReg;
      D_ERR:   rdVal = errReg;
      D_ID:    rdVal = idReg;
      default: rdVal = devReq.addr < 5'h08 ? rxBytes[devReq.addr[2:0]*8 +: 8] : 8'h00;
    endcase
  end

  // The host samples at the end of the cycle in which it holds the read, so answer there;
  // elsewhere the lines keep changing so a late or early sample shows up
  assign devRdata = devReq.rd ? rdVal : junkReg;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) junkReg <= 8'h00;
    else junkReg <= ~junkReg;
  end

  // Status flags and the level interrupt, held until the clear command
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      statReg <= 8'h00;
      errReg  <= 8'h00;
      idReg   <= 8'h00;
      devIrq  <= 1'b0;
    end else begin
      if (ctrlWr && (devReq.wdata & CM_RSTI) != 8'h00) begin
        devIrq  <= 1'b0;
        statReg <= statReg & 8'h04; // Error flag survives until its own clear
      end
      if (ctrlWr && (devReq.wdata & CM_RSTE) != 8'h00) begin
        statReg[S_ERR] <= 1'b0;
        errReg         <= 8'h00;
      end
      if (evHdr) begin
        statReg[S_HDR] <= 1'b1;
        idReg          <= evId;
      end
      if (evDone) statReg[S_DONE] <= 1'b1;
      if (evErr) begin
        statReg[S_ERR] <= 1'b1;
        errReg         <= evCode;
      end
      if (evWake) statReg[S_WAKE] <= 1'b1;
      if (evIdle) statReg[S_IDLE] <= 1'b1;
      if (evHdr || evDone || evErr || evWake || evIdle) devIrq <= 1'b1;
    end
  end

  // Configuration writes and a record of control commands seen
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dlenReg  <= 8'h00;
      btloReg  <= 8'h00;
      bthiReg  <= 8'h00;
      swReg    <= 8'h00;
      tmReg    <= 8'h00;
      wakeSent <= 1'b0;
      ctrlSeen <= 8'h00;
    end else begin
      if (devReq.wr) begin
        case (devReq.addr)
          D_DLEN:  dlenReg <= devReq.wdata;
          D_BTLO:  btloReg <= devReq.wdata;
          D_BTHI:  bthiReg <= devReq.wdata;
          D_SW:    swReg   <= devReq.wdata;
          D_TIME:  tmReg   <= devReq.wdata;
          default: ;
        endcase
      end
      if (seenClr) wakeSent <= 1'b0;
      else if (ctrlWr && (devReq.wdata & CM_WAKE) != 8'h00 && !statReg[S_ERR]) wakeSent <= 1'b1;
      ctrlSeen <= seenClr ? 8'h00 : ctrlSeen | (ctrlWr ? devReq.wdata : 8'h00);
    end
  end

  // Transmit buffer; no reset, the host fills it before use
  always_ff @(posedge clock) begin
    if (devReq.wr && devReq.addr < 5'h08) txMem[devReq.addr[2:0]] <= devReq.wdata;
  end
endmodule // lsfc_core_model

/* tb/lsfc_host_test.sv */
// Self-checking bench for the LIN slave host controller.
// Assumes the core model above stands on the device port.
`timescale 1ns/100ps
module lsfc_host_test;
  import lsfc_pkg::*;
  localparam logic [63:0] RXPAT = 64'h8877_6655_4433_2211;
  logic          clock, reset, swWr, swRd, devIrq, seenClr;
  logic          evHdr, evDone, evErr, evWake, evIdle;
  logic [3:0]    swAddr;
  logic [7:0]    swWdata, swRdata, devRdata, evId, evCode;
  logic [63:0]   rxBytes;
  lsfc_dev_req_t devReq;
  int            errCount, cmpCount;

  lsfc_host uut (.clock(clock), .reset(reset), .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr),
                 .swRd(swRd), .swRdata(swRdata), .devReq(devReq), .devRdata(devRdata), .devIrq(devIrq));
  lsfc_core_model mdl (.clock(clock), .reset(reset), .devReq(devReq), .devRdata(devRdata), .devIrq(devIrq),
                       .evHdr(evHdr), .evId(evId), .evDone(evDone), .evErr(evErr), .evCode(evCode),
                       .evWake(evWake), .evIdle(evIdle), .rxBytes(rxBytes), .seenClr(seenClr));

  // Free-running 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmpCount++;
    if (g !== e) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    swAddr  <= a;
    swWdata <= d;
    swWr    <= 1'b1;
    @(posedge clock);
    swWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    @(posedge clock);
    swAddr <= a;
    swRd   <= 1'b1;
    @(posedge clock);
    swRd <= 1'b0;
    #1 chk8(n, e, swRdata & m);
  endtask

  // Pulse core events, then wait, bounded, for the host to clear the interrupt
  task automatic svc(input logic [4:0] ev, input logic [7:0] id);
    int n;
    n = 0;
    @(posedge clock);
    {evIdle, evHdr, evDone, evErr, evWake} <= ev;
    evId    <= id;
    seenClr <= 1'b1;
    @(posedge clock);
    {evIdle, evHdr, evDone, evErr, evWake} <= 5'h00;
    seenClr <= 1'b0;
    #1;
    while (devIrq !== 1'b0 && n < 300) begin
      @(posedge clock);
      #1 n++;
    end
    chk8("irq cleared", 8'h00, {7'h00, devIrq});
    repeat (6) @(posedge clock);
  endtask

  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #200000;
    errCount++;
    wrapUp();
  end

  // Test sequence
  initial begin
    {reset, swWr, swRd, seenClr, evHdr, evDone, evErr, evWake} = 8'hFF & 8'h80;
    evIdle = 1'b0;
    reset = 1'b1;
    {swAddr, swWdata, evId} = 20'h0_0000;
    evCode  = 8'h05;
    rxBytes = RXPAT;
    errCount = 0;
    cmpCount = 0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rdChk(H_TXID, 8'hFF, 8'h00, "txid reset");
    rdChk(H_RXID, 8'hFF, 8'h01, "rxid reset");
    rdChk(H_TIME, 8'hFF, 8'h00, "time reset");
    rdChk(4'h7, 8'hFF, 8'h00, "unmapped");
    $display("test reset done");
    wr(H_TIME, 8'h0E);
    rdChk(H_TIME, 8'hFF, 8'h0E, "time select");
    wr(H_CTRL, 8'h01);
    repeat (30) @(posedge clock);
    chk8("bit time low", BTLO_VAL, mdl.btloReg);
    chk8("bit time high", BTHI_VAL, mdl.bthiReg);
    chk8("time sent", 8'h0E, mdl.tmReg);
    $display("test init done");
    wr(H_RXID, 8'h25);
    wr(H_CTRL, 8'h10);
    svc(5'h08, 8'h25);
    chk8("rx length", 8'h8F, mdl.dlenReg);
    chk8("rx ack", CM_ACK, mdl.ctrlSeen & (CM_ACK | CM_DIR | CM_STOP));
    chk8("rx clear", CM_RSTI | CM_RSTE, mdl.ctrlSeen & (CM_RSTI | CM_RSTE));
    svc(5'h04, 8'h00);
    for (int i = 0; i < 8; i++) rdChk(4'(8 + i), 8'hFF, RXPAT[8*i +: 8], "rx byte");
    rdChk(H_STAT, 8'h01, 8'h01, "rx done flag");
    wr(H_STAT, 8'h01);
    rdChk(H_STAT, 8'h01, 8'h00, "rx done cleared");
    $display("test receive done");
    for (int i = 0; i < 8; i++) wr(4'(8 + i), 8'(8'hA0 + i));
    wr(H_TXID, 8'h3A);
    wr(H_CTRL, 8'h00);
    svc(5'h08, 8'h3A);
    for (int i = 0; i < 8; i++) chk8("tx byte", 8'(8'hA0 + i), mdl.txMem[i]);
    chk8("tx length", 8'h0F, mdl.dlenReg);
    chk8("tx ack", CM_ACK | CM_DIR, mdl.ctrlSeen & (CM_ACK | CM_DIR | CM_STOP));
    $display("test transmit done");
    svc(5'h08, 8'h11);
    chk8("unknown id", CM_STOP, mdl.ctrlSeen & (CM_ACK | CM_STOP));
    $display("test unknown done");
    svc(5'h02, 8'h00);
    rdChk(H_ERR, 8'hFF, 8'h05, "error code");
    rdChk(H_STAT, 8'h02, 8'h02, "error seen");
    chk8("error clear", CM_RSTE, mdl.ctrlSeen & CM_RSTE);
    $display("test error done");
    svc(5'h10, 8'h00);
    rdChk(H_STAT, 8'h08, 8'h08, "idle sleep");
    chk8("idle sleep cmd", CM_SLEEP, mdl.ctrlSeen & CM_SLEEP);
    svc(5'h01, 8'h00);
    rdChk(H_STAT, 8'h0C, 8'h04, "wake seen");
    svc(5'h00, 8'h00);
    wr(H_CTRL, 8'h04);
    repeat (30) @(posedge clock);
    chk8("sleep cmd", CM_SLEEP, mdl.ctrlSeen & CM_SLEEP);
    rdChk(H_STAT, 8'h08, 8'h08, "sleep set");
    svc(5'h00, 8'h00);
    wr(H_CTRL, 8'h02);
    repeat (30) @(posedge clock);
    chk8("wake sent", 8'h01, {7'h00, mdl.wakeSent});
    wr(H_STAT, 8'h07);
    rdChk(H_STAT, 8'h07, 8'h00, "flags cleared");
    svc(5'h03, 8'h00);
    rdChk(H_STAT, 8'h06, 8'h06, "wake timeout");
    $display("test wake done");
    wr(H_CTRL, 8'h08);
    repeat (30) @(posedge clock);
    chk8("switch closed", 8'h01, {7'h00, |mdl.swReg});
    rdChk(H_CTRL, 8'hFF, 8'h08, "ctrl readback");
    wr(H_CTRL, 8'h00);
    repeat (30) @(posedge clock);
    chk8("switch open", 8'h00, {7'h00, |mdl.swReg});
    $display("test switch done");
    wrapUp();
  end
endmodule // lsfc_host_test
